// [inc/fbp_pkg.sv]
// Package of constants and types for the flash block protection gate.
package fbp_pkg;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int ArrayBytes = 262144;
	localparam int WordBytes = 4;
	localparam int ArrayWords = ArrayBytes / WordBytes;
	localparam int AddrW = 16;
	localparam int UnitBytes = 1024;
	localparam int UnitWords = UnitBytes / WordBytes;
	localparam int UnitAw = 8;
	localparam int NumUnits = ArrayBytes / UnitBytes;
	localparam int UnitIdxW = 8;
	localparam int NumPairs = NumUnits / 2;
	localparam int PairIdxW = 7;
	localparam int PairLsb = 9;
	localparam logic [31:0] ErasedWord = 32'hFFFFFFFF;
	localparam logic [31:0] DeniedWord = 32'h00000000;

	// ****************************************
	// Protection, requester and state encodings
	// ****************************************
	typedef enum logic [1:0] {
		FBP_OPEN = 2'h0,
		FBP_READ_ONLY = 2'h1,
		FBP_EXEC_ONLY = 2'h2
	} fbp_prot_e;

	localparam fbp_prot_e ProtReset = FBP_OPEN;

	typedef enum logic [1:0] {
		FBP_SRC_FETCH = 2'h0,
		FBP_SRC_DATA = 2'h1,
		FBP_SRC_DEBUG = 2'h2
	} fbp_src_e;

	typedef enum logic [2:0] {
		FBP_ST_IDLE = 3'b001,
		FBP_ST_ERASE = 3'b010,
		FBP_ST_DONE = 3'b100
	} fbp_state_e;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic valid;
		fbp_src_e src;
		logic [AddrW-1:0] addr;
	} fbp_read_req_s;

	typedef struct packed {
		logic valid;
		logic erase;
		logic [AddrW-1:0] addr;
		logic [31:0] data;
	} fbp_mod_req_s;

	typedef struct packed {
		logic valid;
		logic [PairIdxW-1:0] pair;
		fbp_prot_e level;
	} fbp_prot_req_s;

	typedef struct packed {
		logic readDenied;
		logic modifyRefused;
	} fbp_viol_s;

endpackage : fbp_pkg

// [logic/fbp_flash_gate.sv]
// Flash array with per-pair protection gating of reads, programs and erases.
`timescale 1ns/1ps

module fbp_flash_gate (
	input wire logic clk,
	input wire logic rst,
	input wire fbp_pkg::fbp_read_req_s rdReq,
	output logic rdValid_q,
	output logic [31:0] rdData_q,
	output logic rdDenied_q,
	input wire fbp_pkg::fbp_mod_req_s modReq,
	output logic modReady_q,
	output logic modDone_q,
	output logic modRefused_q,
	input wire fbp_pkg::fbp_prot_req_s protReq,
	input wire logic violClear,
	output fbp_pkg::fbp_viol_s viol_q
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		fbp_pkg::fbp_state_e state;
		logic [fbp_pkg::UnitIdxW-1:0] unit;
		logic [fbp_pkg::UnitAw-1:0] cnt;
		logic rdValid;
		logic [31:0] rdData;
		logic rdDenied;
		logic modReady;
		logic modDone;
		logic modRefused;
		fbp_pkg::fbp_viol_s viol;
	} fbp_gate_s;

	fbp_gate_s st_q;
	fbp_gate_s st_d;

	// The array itself; erase walks one word per cycle, so no wide write port is needed.
	logic [31:0] mem [fbp_pkg::ArrayWords];

	fbp_pkg::fbp_prot_e rdLevel;
	fbp_pkg::fbp_prot_e modLevel;
	logic memWe;
	logic [fbp_pkg::AddrW-1:0] memWa;
	logic [31:0] memWd;

	// ****************************************
	// Request decode
	// ****************************************
	// Each decision of the next-state logic is named here, so that every branch below reads as one choice.
	// All of them look at the request of this cycle and at state that was registered before it.
	logic [fbp_pkg::PairIdxW-1:0] rdPair;
	logic [fbp_pkg::PairIdxW-1:0] modPair;
	logic [fbp_pkg::UnitIdxW-1:0] modUnit;
	logic rdPermit;
	logic modBlocked;
	logic eraseLast;
	logic [31:0] storedWord;
	logic [31:0] progWord;
	logic violSetRead;
	logic violSetMod;

	// A pair is 512 words, so its index is the address bits above the word offset within the pair.
	function automatic logic [fbp_pkg::PairIdxW-1:0] pairOf(input logic [fbp_pkg::AddrW-1:0] a);
		pairOf = a[fbp_pkg::AddrW-1:fbp_pkg::PairLsb];
	endfunction : pairOf

	function automatic logic modLocked(input fbp_pkg::fbp_prot_e lv);
		modLocked = (lv != fbp_pkg::FBP_OPEN);
	endfunction : modLocked

	fbp_prot_table uTable (
		.clk(clk),
		.rst(rst),
		.protReq(protReq),
		.rdPairA(rdPair),
		.rdPairB(modPair),
		.levelA(rdLevel),
		.levelB(modLevel)
	);

	assign rdPair = pairOf(rdReq.addr);
	assign modPair = pairOf(modReq.addr);
	assign modUnit = modReq.addr[fbp_pkg::AddrW-1:fbp_pkg::UnitAw];
	// Only a non-fetch read of an execute-only pair is turned away; fetches always get through.
	assign rdPermit = (rdLevel != fbp_pkg::FBP_EXEC_ONLY) || (rdReq.src == fbp_pkg::FBP_SRC_FETCH);
	assign modBlocked = modLocked(modLevel);
	assign eraseLast = &st_q.cnt;
	// A program can only pull bits low; the erase walk alone brings them back to one.
	assign storedWord = mem[modReq.addr];
	assign progWord = storedWord & modReq.data;
	// Modify requests are looked at in the idle state only; one given during an erase walk is dropped.
	assign violSetRead = rdReq.valid && !rdPermit;
	assign violSetMod = (st_q.state == fbp_pkg::FBP_ST_IDLE) && modReq.valid && modBlocked;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic rdOk;
		logic clearViol;
		rdOk = 1'b0;
		clearViol = violClear;
		st_d = st_q;
		st_d.rdValid = rdReq.valid;
		st_d.rdData = fbp_pkg::DeniedWord;
		st_d.rdDenied = 1'b0;
		st_d.modDone = 1'b0;
		st_d.modRefused = 1'b0;
		memWe = 1'b0;
		memWa = modReq.addr;
		memWd = 32'h00000000;
		if (clearViol) begin
			st_d.viol = '0;
		end
		// Reads are answered the very next edge regardless of erase traffic.
		if (rdReq.valid) begin
			rdOk = rdPermit;
			if (rdOk) begin
				st_d.rdData = mem[rdReq.addr];
			end else begin
				st_d.rdDenied = 1'b1;
			end
		end
		unique case (st_q.state)
			fbp_pkg::FBP_ST_IDLE: begin
				if (modReq.valid) begin
					if (modBlocked) begin
						st_d.modRefused = 1'b1;
						st_d.modDone = 1'b1;
					end else if (modReq.erase) begin
						st_d.unit = modUnit;
						st_d.cnt = '0;
						st_d.modReady = 1'b0;
						st_d.state = fbp_pkg::FBP_ST_ERASE;
					end else begin
						memWe = 1'b1;
						memWd = progWord;
						st_d.modDone = 1'b1;
					end
				end
			end
			fbp_pkg::FBP_ST_ERASE: begin
				// One word a cycle keeps a single write port; the price is 256 busy cycles per unit.
				memWe = 1'b1;
				memWa = {st_q.unit, st_q.cnt};
				memWd = fbp_pkg::ErasedWord;
				st_d.cnt = st_q.cnt + 1'b1;
				if (eraseLast) begin
					st_d.state = fbp_pkg::FBP_ST_DONE;
				end
			end
			fbp_pkg::FBP_ST_DONE: begin
				st_d.modDone = 1'b1;
				st_d.modReady = 1'b1;
				st_d.state = fbp_pkg::FBP_ST_IDLE;
			end
			default: begin
				st_d.state = fbp_pkg::FBP_ST_IDLE;
				st_d.modReady = 1'b1;
			end
		endcase
		// Flags are set after the clear above, so an event in the cycle of a clear still leaves its flag set.
		if (violSetRead) begin
			st_d.viol.readDenied = 1'b1;
		end
		if (violSetMod) begin
			st_d.viol.modifyRefused = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Reset opens the way for new requests but leaves the array alone.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
			st_q.state <= fbp_pkg::FBP_ST_IDLE;
			st_q.modReady <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Array
	// ****************************************
	// Contents survive reset, as a real flash array would.
	always_ff @(posedge clk) begin
		if (memWe) begin
			mem[memWa] <= memWd;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Every output is a field of the state register, so no request reaches an output combinationally.
	assign rdValid_q = st_q.rdValid;
	assign rdData_q = st_q.rdData;
	assign rdDenied_q = st_q.rdDenied;
	assign modReady_q = st_q.modReady;
	assign modDone_q = st_q.modDone;
	assign modRefused_q = st_q.modRefused;
	assign viol_q = st_q.viol;

endmodule : fbp_flash_gate

// [logic/fbp_prot_table.sv]
// Per-pair protection level table.
`timescale 1ns/1ps

module fbp_prot_table (
	input wire logic clk,
	input wire logic rst,
	input wire fbp_pkg::fbp_prot_req_s protReq,
	input wire logic [fbp_pkg::PairIdxW-1:0] rdPairA,
	input wire logic [fbp_pkg::PairIdxW-1:0] rdPairB,
	output fbp_pkg::fbp_prot_e levelA,
	output fbp_pkg::fbp_prot_e levelB
);

	typedef struct packed {
		fbp_pkg::fbp_prot_e [fbp_pkg::NumPairs-1:0] level;
	} fbp_tab_s;

	fbp_tab_s st_q;
	fbp_tab_s st_d;

	always_comb begin
		st_d = st_q;
		if (protReq.valid) begin
			st_d.level[protReq.pair] = protReq.level;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < fbp_pkg::NumPairs; i++) begin
				st_q.level[i] <= fbp_pkg::ProtReset;
			end
		end else begin
			st_q <= st_d;
		end
	end

	assign levelA = st_q.level[rdPairA];
	assign levelB = st_q.level[rdPairB];

endmodule : fbp_prot_table

// [sim/fbp_flash_gate_bench.sv]
// Self-checking bench of the flash protection gate.
`timescale 1ns/1ps
module fbp_flash_gate_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic violClear = 1'b0;
	fbp_pkg::fbp_prot_req_s protReq = '0;
	fbp_pkg::fbp_read_req_s rdReq;
	fbp_pkg::fbp_mod_req_s modReq;
	fbp_pkg::fbp_viol_s viol_q;
	logic rdValid_q, rdDenied_q, modReady_q, modDone_q, modRefused_q;
	logic [31:0] rdData_q;
	int n_errors = 0;
	int comparisons = 0;
	fbp_requester p (.clk(clk), .rdReq(rdReq), .modReq(modReq));
	fbp_flash_gate uut (.clk(clk), .rst(rst), .rdReq(rdReq), .rdValid_q(rdValid_q), .rdData_q(rdData_q),
		.rdDenied_q(rdDenied_q), .modReq(modReq), .modReady_q(modReady_q), .modDone_q(modDone_q),
		.modRefused_q(modRefused_q), .protReq(protReq), .violClear(violClear), .viol_q(viol_q));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input fbp_pkg::fbp_src_e s, input logic [15:0] a, input logic [31:0] d, input logic dn);
		p.rd(s, a);
		#1;
		chk({rdValid_q, rdDenied_q, rdData_q}, {1'b1, dn, d});
		@(posedge clk);
	endtask : rd
	task automatic md(input logic e, input logic [15:0] a, input logic [31:0] d, input logic rf);
		int i;
		i = 0;
		p.md(e, a, d);
		#1;
		while (modDone_q !== 1'b1 && i < 300) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk({modDone_q, modRefused_q}, {1'b1, rf});
		@(posedge clk);
	endtask : md
	task automatic prot(input fbp_pkg::fbp_prot_e l);
		protReq <= '{1'b1, 7'h00, l};
		@(posedge clk);
		protReq <= '0;
		@(posedge clk);
	endtask : prot
	task automatic t_erase();
		md(1'b1, 16'h0100, '0, 1'b0);
		md(1'b0, 16'h0100, 32'h12345678, 1'b0);
		md(1'b1, 16'h0000, '0, 1'b0);
		rd(fbp_pkg::FBP_SRC_DATA, 16'h00FF, 32'hFFFFFFFF, 1'b0);
		rd(fbp_pkg::FBP_SRC_DEBUG, 16'h0100, 32'h12345678, 1'b0);
	endtask : t_erase
	task automatic t_program();
		md(1'b0, 16'h0005, 32'hF0F01234, 1'b0);
		md(1'b0, 16'h0005, 32'h0F0FFFFF, 1'b0);
		rd(fbp_pkg::FBP_SRC_FETCH, 16'h0005, 32'h00001234, 1'b0);
	endtask : t_program
	task automatic t_protect();
		prot(fbp_pkg::FBP_READ_ONLY);
		md(1'b0, 16'h0100, '0, 1'b1);
		md(1'b1, 16'h0000, '0, 1'b1);
		rd(fbp_pkg::FBP_SRC_DATA, 16'h0005, 32'h00001234, 1'b0);
		chk(viol_q, 2'h1);
		prot(fbp_pkg::FBP_EXEC_ONLY);
		md(1'b0, 16'h0005, '0, 1'b1);
		rd(fbp_pkg::FBP_SRC_FETCH, 16'h0005, 32'h00001234, 1'b0);
		rd(fbp_pkg::FBP_SRC_DATA, 16'h0005, '0, 1'b1);
		rd(fbp_pkg::FBP_SRC_DEBUG, 16'h0100, '0, 1'b1);
		chk(viol_q, 2'h3);
		violClear <= 1'b1;
		p.rd(fbp_pkg::FBP_SRC_DATA, 16'h0005);
		violClear <= 1'b0;
		#1;
		chk(viol_q, 2'h2);
		@(posedge clk);
		violClear <= 1'b1;
		@(posedge clk);
		violClear <= 1'b0;
		#1;
		chk(viol_q, 2'h0);
		@(posedge clk);
		prot(fbp_pkg::FBP_OPEN);
		rd(fbp_pkg::FBP_SRC_DATA, 16'h0100, 32'h12345678, 1'b0);
	endtask : t_protect
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (12) @(posedge clk);
		chk({modReady_q, modDone_q, modRefused_q, rdValid_q, rdDenied_q, viol_q}, 7'h40);
		rst <= 1'b0;
		@(posedge clk);
		t_erase();
		t_program();
		t_protect();
		close_out();
	end
	initial begin
		#50000;
		n_errors++;
		close_out();
	end
endmodule : fbp_flash_gate_bench

// [sim/fbp_flash_gate_props.sv]
// Port checks for the flash protection gate.
`timescale 1ns/1ps
module fbp_flash_gate_props (
	input logic clk,
	input logic rst,
	input fbp_pkg::fbp_read_req_s rdReq,
	input logic rdValid_q,
	input logic [31:0] rdData_q,
	input logic rdDenied_q,
	input fbp_pkg::fbp_mod_req_s modReq,
	input logic modReady_q,
	input logic modDone_q,
	input logic modRefused_q
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence progGo;
		modReq.valid && !modReq.erase && modReady_q;
	endsequence
	sequence eraseGo;
		modReq.valid && modReq.erase && modReady_q ##1 !modDone_q;
	endsequence
	chk_read_answer: assert property (rdReq.valid |=> rdValid_q) else $error("late read");
	chk_read_idle: assert property (!rdReq.valid |=> !rdValid_q && rdData_q == '0) else $error("idle read");
	chk_deny_zero: assert property (rdDenied_q |-> rdValid_q && rdData_q == '0) else $error("denied data");
	chk_fetch_served: assert property (rdReq.valid && rdReq.src == fbp_pkg::FBP_SRC_FETCH |=> !rdDenied_q)
		else $error("fetch denied");
	chk_refuse_done: assert property (modRefused_q |-> modDone_q) else $error("lone refuse");
	chk_prog_done: assert property (progGo |=> modDone_q) else $error("late program");
	chk_erase_busy: assert property (eraseGo |-> !modReady_q [*8]) else $error("ready in erase");
	chk_erase_span: assert property (eraseGo |-> ##257 (modDone_q && modReady_q)) else $error("erase span");
endmodule : fbp_flash_gate_props
bind fbp_flash_gate fbp_flash_gate_props chk (.clk(clk), .rst(rst), .rdReq(rdReq), .rdValid_q(rdValid_q),
	.rdData_q(rdData_q), .rdDenied_q(rdDenied_q), .modReq(modReq), .modReady_q(modReady_q),
	.modDone_q(modDone_q), .modRefused_q(modRefused_q));

// [sim/fbp_requester.sv]
// Requester model: fetch, data and debugger side of the gate.
`timescale 1ns/1ps
module fbp_requester (
	input wire logic clk,
	output fbp_pkg::fbp_read_req_s rdReq,
	output fbp_pkg::fbp_mod_req_s modReq
);
	initial begin
		rdReq = '0;
		modReq = '0;
	end
	task automatic rd(input fbp_pkg::fbp_src_e s, input logic [15:0] a);
		rdReq <= '{1'b1, s, a};
		@(posedge clk);
		rdReq <= '0;
	endtask : rd
	task automatic md(input logic e, input logic [15:0] a, input logic [31:0] d);
		modReq <= '{1'b1, e, a, d};
		@(posedge clk);
		modReq <= '0;
	endtask : md
endmodule : fbp_requester
